/* File: verilog/lmf_regs.sv */
// Mode control and fault interrupt registers of the charge-pump LED driver
`timescale 1ns/1ps
// How it works
// - Config bit 1: interrupt released for 50 us from a clear, then re-driven if pending.
// - Config bit 0: interrupt stays asserted without gap while events pend.
// - Active/standby bit 1 gives active mode; 0 gives standby.
// - Dim bit set by dim timeout, or forced by host writing 1.
// - Dim current only while dim bit and backlight enable are both 1.
// - Gain-down inhibit 1: pump may raise gain, lowers only when LEDs off.
// - Gain-down inhibit 0: pump raises and lowers gain freely.
// - Sync sink enable turns all independent sinks on or off together.
// - Sync sink enable ignored while any per-sink enable bit is set.
// - Backlight on only with backlight enable and active bit both 1.
// - Short flag set on pump output short or overload.
// - Overtemperature flag set when thermal detector trips.
// - Overvoltage flag set when pump output exceeds its threshold.
// - Fault flags clear only on write of 1, reset or lockout; reads and zeros leave them.
// - Short flag with its enable raises the interrupt.
// - Overtemperature flag with its enable raises the interrupt.
// - Overvoltage flag with its enable raises the interrupt.
// - Disabled enables still let flags set and hold.
// - Reserved and unused bits read as zero.
// - Reset and undervoltage lockout restore all defaults.
module lmf_regs
  import lmf_pkg::*;
(
  input wire logic clk, // 125 MHz device clock
  input wire logic rst, // Async reset, active high
  input wire logic uvlo, // Undervoltage lockout, sync
  input wire lmf_pkg::lmf_req_s req, // Register access from serial interface
  output logic [7:0] rdata, // Read data, registered
  input wire lmf_pkg::lmf_fault_s fault, // Fault detector pulses or levels
  input wire logic dim_timeout, // Dim timer expiry pulse
  input wire logic [6:0] per_sink_on, // Per-sink enables of sink control reg
  input wire logic [6:0] indep_sel, // Sinks designated independent
  input wire logic all_leds_off, // Every LED sink is off
  output logic active, // Device active (not standby)
  output logic backlight_on, // Backlight running
  output logic dim_active, // Backlight at dim current
  output logic gain_down_ok, // Pump may step gain down
  output logic [6:0] indep_sink_on, // Sync enables of independent sinks
  output logic irq_n // Interrupt to host, active low
);
  import lmf_pkg::*;

  logic [7:0] mode_q;
  logic [7:0] fault_q;
  logic [7:0] irqen_q;
  logic [7:0] fault_set;
  logic [7:0] fault_clr;
  logic wr_mode;
  logic wr_fault;
  logic wr_irqen;
  logic irq_req;
  logic clr_evt;
  lmf_irq_e irq_st_q;
  logic [15:0] gap_cnt_q;
  logic irq_n_q;

  assign wr_mode = req.wr && (req.addr == LMF_ADDR_MODE);
  assign wr_fault = req.wr && (req.addr == LMF_ADDR_FAULT);
  assign wr_irqen = req.wr && (req.addr == LMF_ADDR_IRQEN);

  // Detector inputs set flags regardless of enables
  assign fault_set = lmf_fault_vec(fault);
  // Only ones written clear; set wins over a clear in the same cycle
  assign fault_clr = wr_fault ? (req.wdata & LMF_FAULT_MASK) : 8'h00;
  assign clr_evt = |fault_clr;

  // Mode control register; hardware dim set has priority over a host write of 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= LMF_MODE_RST;
    end else if (uvlo) begin
      mode_q <= LMF_MODE_RST;
    end else begin
      if (wr_mode) begin
        mode_q <= req.wdata & LMF_MODE_MASK;
      end
      if (dim_timeout) begin
        mode_q[LMF_B_DIM] <= 1'b1;
      end
    end
  end

  // Fault status flags, sticky until write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_q <= LMF_FAULT_RST;
    end else if (uvlo) begin
      fault_q <= LMF_FAULT_RST;
    end else begin
      fault_q <= ((fault_q & ~fault_clr) | fault_set) & LMF_FAULT_MASK;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqen_q <= LMF_IRQEN_RST;
    end else if (uvlo) begin
      irqen_q <= LMF_IRQEN_RST;
    end else if (wr_irqen) begin
      irqen_q <= req.wdata & LMF_FAULT_MASK;
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        LMF_ADDR_MODE: rdata <= mode_q;
        LMF_ADDR_FAULT: rdata <= fault_q;
        LMF_ADDR_IRQEN: rdata <= irqen_q;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Pending request from the stored flags; a clear takes effect one edge later
  assign irq_req = |(fault_q & irqen_q);

  // Release window after a host clear when configured for it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_st_q <= LMF_IDLE;
      gap_cnt_q <= 16'h0000;
    end else if (uvlo) begin
      irq_st_q <= LMF_IDLE;
      gap_cnt_q <= 16'h0000;
    end else begin
      case (irq_st_q)
        LMF_IDLE: begin
          if (clr_evt && mode_q[LMF_B_IRQ_CFG]) begin
            irq_st_q <= LMF_GAP;
            gap_cnt_q <= 16'(LMF_GAP_CYC - 1);
          end
        end
        LMF_GAP: begin
          if (gap_cnt_q == 16'h0000) begin
            irq_st_q <= LMF_IDLE;
          end else begin
            gap_cnt_q <= gap_cnt_q - 16'h0001;
          end
        end
        default: begin
          irq_st_q <= LMF_IDLE;
        end
      endcase
    end
  end

  // Registered pin; with config 0 there is no gap at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~(irq_req && (irq_st_q == LMF_IDLE) &&
                   !(clr_evt && mode_q[LMF_B_IRQ_CFG]));
    end
  end
  assign irq_n = irq_n_q;

  // Mode outputs; standby holds every drive off
  assign active = mode_q[LMF_B_ACTIVE];
  assign backlight_on = active && mode_q[LMF_B_BL];
  assign dim_active = backlight_on && mode_q[LMF_B_DIM];
  // Inhibit lets gain step down only once all LEDs are off
  assign gain_down_ok = !mode_q[LMF_B_GDWN] || all_leds_off;
  // Per-sink enables take over the sync bit while any is set
  assign indep_sink_on = (active && mode_q[LMF_B_SIS] && !(|per_sink_on)) ?
                         indep_sel : 7'h00;

endmodule // lmf_regs

/* File: include/lmf_pkg.sv */
// Package for the LED driver mode and fault interrupt register bank
package lmf_pkg;
  // Register offsets
  localparam logic [7:0] LMF_ADDR_MODE = 8'h01;
  localparam logic [7:0] LMF_ADDR_FAULT = 8'h02;
  localparam logic [7:0] LMF_ADDR_IRQEN = 8'h03;
  // Mode control bit positions
  localparam int LMF_B_IRQ_CFG = 6;
  localparam int LMF_B_ACTIVE = 5;
  localparam int LMF_B_DIM = 4;
  localparam int LMF_B_GDWN = 3;
  localparam int LMF_B_SIS = 2;
  localparam int LMF_B_BL = 0;
  // Fault and enable bit positions
  localparam int LMF_B_SHORT = 4;
  localparam int LMF_B_OTEMP = 3;
  localparam int LMF_B_OVOLT = 2;
  // Writable masks, reserved bits read zero
  localparam logic [7:0] LMF_MODE_MASK = 8'h7d;
  localparam logic [7:0] LMF_FAULT_MASK = 8'h1c;
  // Reset values
  localparam logic [7:0] LMF_MODE_RST = 8'h00;
  localparam logic [7:0] LMF_FAULT_RST = 8'h00;
  localparam logic [7:0] LMF_IRQEN_RST = 8'h00;
  // Interrupt release gap
  localparam int LMF_CLK_MHZ = 125;
  localparam int LMF_GAP_US = 50;
  localparam int LMF_GAP_CYC = LMF_GAP_US * LMF_CLK_MHZ;
  localparam int LMF_NSINK = 7;

  // Register access request from the serial interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmf_req_s;

  // Fault detector indications
  typedef struct packed {
    logic short_det;
    logic otemp_det;
    logic ovolt_det;
  } lmf_fault_s;

  typedef enum logic [1:0] {
    LMF_IDLE = 2'b00,
    LMF_GAP = 2'b01
  } lmf_irq_e;

  // Fault bit vector from the detector struct
  function automatic logic [7:0] lmf_fault_vec(input lmf_fault_s f);
    logic [7:0] v;
    v = 8'h00;
    v[LMF_B_SHORT] = f.short_det;
    v[LMF_B_OTEMP] = f.otemp_det;
    v[LMF_B_OVOLT] = f.ovolt_det;
    return v;
  endfunction
endpackage

/* File: sim/lmf_host.sv */
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module lmf_host
  import lmf_pkg::*;
(
  input wire logic clk, // Device clock
  input wire logic [7:0] rdata, // Read data
  output lmf_pkg::lmf_req_s req // Access strobe
);
  initial req = '0;
  // Strobe held to the taking edge; data sampled after it settles
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    #1 req = '{w, !w, a, d};
    @(posedge clk);
    #1 req = '0;
    @(posedge clk);
    #1 q = rdata;
  endtask
endmodule // lmf_host

/* File: sim/lmf_regs_sva.sv */
// Port assertions for the mode and fault registers
`timescale 1ns/1ps
module lmf_regs_sva
  import lmf_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic uvlo, // Lockout
  input wire lmf_pkg::lmf_req_s req, // Access
  input wire logic [7:0] rdata, // Read data
  input wire lmf_pkg::lmf_fault_s fault, // Detectors
  input wire logic dim_timeout, // Dim expiry
  input wire logic [6:0] per_sink_on, // Sink enables
  input wire logic [6:0] indep_sel, // Independent sinks
  input wire logic all_leds_off, // LEDs off
  input wire logic active, // Active
  input wire logic backlight_on, // Backlight
  input wire logic dim_active, // Dim
  input wire logic gain_down_ok, // Gain down
  input wire logic [6:0] indep_sink_on, // Sync sinks
  input wire logic irq_n // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Host mode write not overridden by lockout
  sequence mode_wr;
    req.wr && req.addr == LMF_ADDR_MODE && !uvlo;
  endsequence
  chk_active_wr: assert property (mode_wr |=> active == $past(req.wdata[5]))
    else $error("active");
  chk_bl_wr: assert property (mode_wr |=> backlight_on == $past(req.wdata[5] & req.wdata[0]))
    else $error("backlight");
  chk_bl_gate: assert property (backlight_on |-> active) else $error("standby");
  chk_dim_gate: assert property (dim_active |-> backlight_on) else $error("dim");
  chk_sink_block: assert property (per_sink_on != 0 || !active |-> indep_sink_on == 0)
    else $error("sink");
  chk_sink_sel: assert property ((indep_sink_on & ~indep_sel) == 0) else $error("sel");
  chk_gain_free: assert property (all_leds_off |-> gain_down_ok) else $error("gain");
  chk_uvlo_clear: assert property (uvlo |=> !active && !backlight_on) else $error("uvlo");
  chk_rd_unmapped: assert property (req.rd && req.addr > 3 |=> rdata == 0)
    else $error("unmapped");
endmodule // lmf_regs_sva
bind lmf_regs lmf_regs_sva lmf_regs_sva_inst (.clk(clk), .rst(rst), .uvlo(uvlo), .req(req),
  .rdata(rdata), .fault(fault), .dim_timeout(dim_timeout), .per_sink_on(per_sink_on),
  .indep_sel(indep_sel), .all_leds_off(all_leds_off), .active(active),
  .backlight_on(backlight_on), .dim_active(dim_active), .gain_down_ok(gain_down_ok),
  .indep_sink_on(indep_sink_on), .irq_n(irq_n));

/* File: sim/lmf_regs_tb.sv */
// Testbench for the mode and fault registers
`timescale 1ns/1ps
module lmf_regs_tb;
  import lmf_pkg::*;
  logic clk, active, backlight_on, dim_active, gain_down_ok, irq_n;
  logic rst = 1, uvlo = 0, dim_timeout = 0, all_leds_off = 0;
  logic [6:0] per_sink_on = 0, indep_sel = 7'h0f, indep_sink_on;
  logic [7:0] rdata, q;
  lmf_req_s req;
  lmf_fault_s fault = '0;
  int mismatches = 0;
  int n_compared = 0;
  lmf_regs lmf_regs_inst (.clk(clk), .rst(rst), .uvlo(uvlo), .req(req), .rdata(rdata),
    .fault(fault), .dim_timeout(dim_timeout), .per_sink_on(per_sink_on),
    .indep_sel(indep_sel), .all_leds_off(all_leds_off), .active(active),
    .backlight_on(backlight_on), .dim_active(dim_active), .gain_down_ok(gain_down_ok),
    .indep_sink_on(indep_sink_on), .irq_n(irq_n));
  lmf_host lmf_host_inst (.clk(clk), .rdata(rdata), .req(req));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    lmf_host_inst.acc(0, a, 0, q);
    chk("rdata", e, q);
  endtask
  task automatic wr(input logic [7:0] a, d);
    lmf_host_inst.acc(1, a, d, q);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well past the 6250-cycle release gap
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  // Inputs change 1 ns after the edge so the design samples them cleanly
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    rd(LMF_ADDR_MODE, 8'h00);
    rd(8'h05, 8'h00);
    wr(LMF_ADDR_MODE, 8'hff);
    rd(LMF_ADDR_MODE, 8'h7d);
    chk("status", 8'he0, {dim_active, backlight_on, active, gain_down_ok, 4'h0});
    chk("sinks", 8'h0f, {1'b0, indep_sink_on});
    per_sink_on = 7'h01;
    all_leds_off = 1;
    #1 chk("sink_gain", 8'h01, {indep_sink_on, gain_down_ok});
    wr(LMF_ADDR_MODE, 8'h65);
    dim_timeout = 1;
    @(posedge clk);
    #1 dim_timeout = 0;
    rd(LMF_ADDR_MODE, 8'h75);
    wr(LMF_ADDR_IRQEN, 8'hff);
    rd(LMF_ADDR_IRQEN, 8'h1c);
    fault = 3'b110;
    @(posedge clk);
    #1 fault = '0;
    rd(LMF_ADDR_FAULT, 8'h18);
    chk("irq", 8'h00, {7'h0, irq_n});
    wr(LMF_ADDR_FAULT, 8'h00);
    rd(LMF_ADDR_FAULT, 8'h18);
    wr(LMF_ADDR_FAULT, 8'h10);
    chk("irq_gap", 8'h01, {7'h0, irq_n});
    repeat (6000) @(posedge clk);
    chk("irq_mid", 8'h01, {7'h0, irq_n});
    repeat (300) @(posedge clk);
    chk("irq_back", 8'h00, {7'h0, irq_n});
    wr(LMF_ADDR_MODE, 8'h25);
    fault = 3'b001;
    @(posedge clk);
    #1 fault = '0;
    wr(LMF_ADDR_FAULT, 8'h08);
    chk("irq_hold", 8'h00, {7'h0, irq_n});
    wr(LMF_ADDR_IRQEN, 8'h00);
    chk("irq_off", 8'h01, {7'h0, irq_n});
    rd(LMF_ADDR_FAULT, 8'h04);
    uvlo = 1;
    @(posedge clk);
    #1 uvlo = 0;
    rd(LMF_ADDR_MODE, 8'h00);
    end_of_test();
  end
endmodule // lmf_regs_tb
